// ### rtl/emb_block.sv
// Embedded memory block: RAM, lookup table and CAM behind a Wishbone slave
// Functional notes
// R01 - Port input registers share one enable, output registers another; four in total.
// R02 - Each port has own read enable, write enable and clear.
// R03 - Every register clears asynchronously from chip reset; ports also clear separately. The code loads the enables with all ones.
// R04 - Dual-port use takes only one half, port A or port B.
// R05 - Single-port access, no simultaneous read and write; two memories per block.
// R06 - One memory may be 4096x1 up to 128x32 words by bits.
// R07 - CAM compares a key with all words at once and returns the address.
// R08 - Match flag is high when any stored word matches.
// R09 - CAM holds 32 words of 32 bits.
// R10 - Bits marked don't-care are left out of the comparison.
// R11 - Three output modes, each with encoded or unencoded address.
// R12 - Encoded output gives the binary number of the matching location.
// R13 - Unencoded output uses 16 one-hot lines over two cycles.
// R14 - Unencoded search uses 31 key bits; one bit selects a bank.
// R15 - Select one reports odd words 1..31, select zero even words 0..30.
// R16 - Single-match: write takes two cycles, search one cycle.
// R17 - Multiple-match: write two cycles, search gives 16 lines per cycle, two cycles.
// R18 - Fast multiple-match: 16 lines in one cycle, only 16 words searched.
// R19 - Words write in two cycles, a third when don't-care bits are given.
// R20 - Output registers can be inserted per port.
// R21 - Locked block acts as a lookup table returning stored results.
// R22 - Encoded multiple-match reports the lowest matching location.
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module emb_block
  import emb_pkg::*;
(
  input  logic            ref_clk_in,
  input  logic            reset_n_in,
  input  emb_wb_req_type  wb_req_in,
  output emb_wb_resp_type wb_resp_out,
  output emb_match_type   match_out,
  output logic            busy_out
);

  typedef struct packed {
    logic [EMB_MEM_ROWS-1:0][31:0]  mem;
    logic [EMB_CAM_WORDS-1:0][31:0] cam_data;
    logic [EMB_CAM_WORDS-1:0][31:0] cam_dc;
    emb_cfg_type                    cfg;
    logic [3:0]                     ena;
    logic [12:0]                    addr;
    logic [31:0]                    wdata;
    logic [1:0][31:0]               raw;
    logic [1:0][31:0]               rdata;
    logic [31:0]                    cam_wdata;
    logic [31:0]                    cam_mask;
    logic [4:0]                     cam_waddr;
    logic [31:0]                    key;
    emb_state_type                  state;
    emb_match_type                  match;
    logic                           busy;
    emb_wb_resp_type                wb;
  } emb_regs_type;

  emb_regs_type st;
  emb_regs_type next_st;

  logic [31:0] hit_v;
  logic [15:0] even_v;
  logic [15:0] odd_v;
  logic [31:0] cmp_mask;
  logic        cam_wr_go;
  logic        search_go;
  logic [1:0]  clr_vec;
  logic        ram_wr;
  logic        ram_rd;

  // Byte-lane merge for classic Wishbone select
  function automatic logic [31:0] sel_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : sel_merge

  // Data lane mask for the configured width; codes above five act as x32
  function automatic logic [31:0] lane_mask(input logic [2:0] w);
    case (w)
      3'h0:    return 32'h0000_0001;
      3'h1:    return 32'h0000_0003;
      3'h2:    return 32'h0000_000F;
      3'h3:    return 32'h0000_00FF;
      3'h4:    return 32'h0000_FFFF;
      default: return 32'hFFFF_FFFF;
    endcase
  endfunction : lane_mask

  // Bit address of a word; a split block pins the top bit to the port
  function automatic logic [11:0] bit_base(input logic [11:0] a,
                                           input logic [2:0]  w,
                                           input logic        split,
                                           input logic        port);
    logic [11:0] b;
    b = a << ((w > 3'h5) ? 3'h5 : w);
    if (split) begin
      b = {port, b[10:0]};  // [R04] [R05]
    end
    return b;
  endfunction : bit_base

  // Lowest set index wins so duplicates report the first location
  function automatic logic [4:0] lowest_hit(input logic [31:0] h);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (h[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : lowest_hit

  // Unencoded search drops the select bit from the compare
  assign cmp_mask = st.cfg.encoded ? 32'hFFFF_FFFF : EMB_UNENC_CMP_MASK;  // [R14]

  // Parallel compare of every stored word against the key
  for (genvar gi = 0; gi < EMB_CAM_WORDS; gi++) begin : g_cmp
    assign hit_v[gi] = (((st.cam_data[gi] ^ st.key) & ~st.cam_dc[gi] & cmp_mask) == 32'h0)
                       && (st.cfg.cam_mode != CAM_FAST || gi < EMB_FAST_WORDS);  // [R07] [R10] [R18]
    if (gi % 2 == 0) begin : g_even
      assign even_v[gi/2] = hit_v[gi];  // [R15]
    end else begin : g_odd
      assign odd_v[gi/2] = hit_v[gi];  // [R15]
    end
  end

  // Next-state logic: bus slave, RAM port, CAM sequencer
  always_comb begin : next_proc
    logic        acc;
    logic [7:0]  ofs;
    logic [31:0] tmp;
    logic        port;
    logic [11:0] base;
    logic [31:0] lmask;
    next_st   = st;
    acc       = wb_req_in.cyc & wb_req_in.stb & ~st.wb.ack;
    ofs       = {wb_req_in.adr[7:2], 2'b00};
    tmp       = 32'h0;
    port      = st.addr[12];
    base      = bit_base(st.addr[11:0], st.cfg.width, st.cfg.split, port);
    lmask     = lane_mask(st.cfg.width);
    cam_wr_go = 1'b0;
    search_go = 1'b0;
    clr_vec   = 2'b00;
    ram_wr    = 1'b0;
    ram_rd    = 1'b0;
    next_st.wb.ack     = acc;  // Answer one cycle after the request, then drop
    next_st.wb.dat     = 32'h0;
    next_st.match.valid = 1'b0;

    // Register reads; unmapped and write-only offsets read zero
    if (acc && !wb_req_in.we) begin
      case (ofs)
        EMB_CTRL_OFS:      next_st.wb.dat = {21'h0, st.cfg};
        EMB_ENA_OFS:       next_st.wb.dat = {28'h0, st.ena};
        EMB_ADDR_OFS:      next_st.wb.dat = {19'h0, st.addr};
        EMB_WDATA_OFS:     next_st.wb.dat = st.wdata;
        EMB_RDATA_A_OFS:   next_st.wb.dat = st.rdata[0];
        EMB_RDATA_B_OFS:   next_st.wb.dat = st.rdata[1];
        EMB_CAM_WDATA_OFS: next_st.wb.dat = st.cam_wdata;
        EMB_CAM_MASK_OFS:  next_st.wb.dat = st.cam_mask;
        EMB_CAM_WADDR_OFS: next_st.wb.dat = {27'h0, st.cam_waddr};
        EMB_CAM_KEY_OFS:   next_st.wb.dat = st.key;
        EMB_STATUS_OFS:    next_st.wb.dat = {8'h0, st.match, st.busy};
        default:           next_st.wb.dat = 32'h0;
      endcase
    end

    // Register writes; commands act on previously loaded address and data
    if (acc && wb_req_in.we) begin
      case (ofs)
        EMB_CTRL_OFS: begin
          tmp = sel_merge({21'h0, st.cfg}, wb_req_in.dat, wb_req_in.sel);
          next_st.cfg = emb_cfg_type'(tmp[10:0]);
        end
        EMB_ENA_OFS: begin
          if (wb_req_in.sel[0]) begin
            next_st.ena = wb_req_in.dat[3:0];  // [R02]
          end
        end
        EMB_CLEAR_OFS: begin
          clr_vec = wb_req_in.dat[1:0] & {2{wb_req_in.sel[0]}};  // [R02]
        end
        EMB_ADDR_OFS: begin
          tmp = sel_merge({19'h0, st.addr}, wb_req_in.dat, wb_req_in.sel);
          next_st.addr = tmp[12:0];
        end
        EMB_WDATA_OFS: next_st.wdata = sel_merge(st.wdata, wb_req_in.dat, wb_req_in.sel);
        EMB_CMD_OFS: begin
          // A write strobe wins; a single port never reads and writes at once
          ram_wr = wb_req_in.dat[0];  // [R05]
          ram_rd = wb_req_in.dat[1] & ~wb_req_in.dat[0];  // [R05]
        end
        EMB_CAM_WDATA_OFS: begin
          next_st.cam_wdata = sel_merge(st.cam_wdata, wb_req_in.dat, wb_req_in.sel);
        end
        EMB_CAM_MASK_OFS: begin
          next_st.cam_mask = sel_merge(st.cam_mask, wb_req_in.dat, wb_req_in.sel);
        end
        EMB_CAM_WADDR_OFS: begin
          // Ignored while a CAM operation runs or the block is not a CAM
          if (st.state == ST_IDLE && st.cfg.cam_en) begin
            cam_wr_go = 1'b1;
            next_st.cam_waddr = wb_req_in.dat[4:0];
          end
        end
        EMB_CAM_KEY_OFS: begin
          if (st.state == ST_IDLE && st.cfg.cam_en) begin
            search_go = 1'b1;
            next_st.key = wb_req_in.dat;
          end
        end
        default: ;
      endcase
    end

    // RAM port access, gated by that port's enables; a locked block is read-only
    if (!st.cfg.cam_en) begin
      if (ram_wr && st.ena[{port, 1'b1}] && !st.cfg.rom_lock) begin  // [R02] [R21]
        next_st.mem[base[11:5]] = (st.mem[base[11:5]] & ~(lmask << base[4:0]))
                                  | ((st.wdata & lmask) << base[4:0]);  // [R06]
      end
      if (ram_rd && st.ena[{port, 1'b0}]) begin  // [R02]
        next_st.raw[port] = (st.mem[base[11:5]] >> base[4:0]) & lmask;  // [R06] [R21]
      end
    end

    // Optional output stage per port costs one cycle of latency
    for (int p = 0; p < 2; p++) begin
      next_st.rdata[p] = st.cfg.out_reg[p] ? st.raw[p] : next_st.raw[p];  // [R20] [R01]
      if (clr_vec[p]) begin
        next_st.raw[p]   = 32'h0;  // [R03]
        next_st.rdata[p] = 32'h0;  // [R03]
      end
    end

    // CAM sequencer
    case (st.state)
      ST_IDLE: begin
        if (cam_wr_go) begin
          next_st.state = ST_WR1;  // [R19]
        end else if (search_go) begin
          next_st.state = ST_SR1;
        end
      end
      ST_WR1: next_st.state = ST_WR2;  // [R16] [R17]
      ST_WR2: begin
        next_st.cam_data[st.cam_waddr] = st.cam_wdata;  // [R09]
        next_st.cam_dc[st.cam_waddr]   = 32'h0;
        next_st.state = (st.cam_mask != 32'h0) ? ST_WR3 : ST_IDLE;  // [R19]
      end
      ST_WR3: begin
        next_st.cam_dc[st.cam_waddr] = st.cam_mask;  // [R10] [R19]
        next_st.state = ST_IDLE;
      end
      ST_SR1: begin
        next_st.match.valid = 1'b1;
        next_st.match.flag  = |hit_v;  // [R08]
        next_st.match.addr  = st.cfg.encoded ? lowest_hit(hit_v) : 5'h00;  // [R12] [R22]
        if (st.cfg.encoded) begin
          next_st.match.lines = 16'h0000;  // [R11]
        end else if (st.cfg.cam_mode == CAM_MULTI) begin
          next_st.match.lines = even_v;  // [R13] [R17]
        end else if (st.cfg.cam_mode == CAM_FAST) begin
          next_st.match.lines = hit_v[15:0];  // [R18]
        end else begin
          next_st.match.lines = st.key[0] ? odd_v : even_v;  // [R15] [R16]
        end
        next_st.state = (st.cfg.cam_mode == CAM_MULTI) ? ST_SR2 : ST_IDLE;  // [R17]
      end
      ST_SR2: begin
        next_st.match.valid = 1'b1;
        next_st.match.lines = st.cfg.encoded ? 16'h0000 : odd_v;  // [R13] [R17]
        next_st.state = ST_IDLE;
      end
      default: next_st.state = ST_IDLE;
    endcase
    next_st.busy = (next_st.state != ST_IDLE);
  end

  // Whole state in one register; chip reset clears all but the enables, which load all ones, without the clock
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin : state_reg
    if (!reset_n_in) begin
      st     <= '0;  // [R03]
      st.ena <= EMB_ENA_RESET;
      st.cfg <= emb_cfg_type'(EMB_CTRL_RESET);
    end else begin
      st <= next_st;
    end
  end

  assign wb_resp_out = st.wb;
  assign match_out   = st.match;
  assign busy_out    = st.busy;

  default clocking def_clk @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  wb_answer_a: assert property (wb_req_in.cyc && wb_req_in.stb && !st.wb.ack |=> st.wb.ack)
    else $error("bus request not answered next cycle");
  // Ack is a one-cycle pulse even while the master still holds its request
  wb_drop_a: assert property (st.wb.ack |=> !st.wb.ack)
    else $error("bus ack held longer than one cycle");
  single_port_a: assert property (ram_wr |-> !ram_rd)  // [R05]
    else $error("read and write strobes together");
  clear_out_a: assert property (clr_vec[0]  // [R02]
                                |=> st.rdata[0] == 32'h0 && st.raw[0] == 32'h0)
    else $error("port A output not cleared");
  cam_write_a: assert property (cam_wr_go |=> st.state == ST_WR1 ##1 st.state == ST_WR2)  // [R19]
    else $error("CAM write did not take two cycles");
  cam_store_a: assert property (st.state == ST_WR2  // [R09]
                                |=> st.cam_data[$past(st.cam_waddr)] == $past(st.cam_wdata))
    else $error("CAM word not stored");
  wr_end_a: assert property (st.state == ST_WR2 && st.cam_mask == 32'h0  // [R16]
                             |=> st.state == ST_IDLE)
    else $error("plain CAM write longer than two cycles");
  dc_third_a: assert property (st.state == ST_WR2 && st.cam_mask != 32'h0  // [R19]
                               |=> st.state == ST_WR3)
    else $error("don't-care write lacks third cycle");
  dc_store_a: assert property (st.state == ST_WR3  // [R10]
                               |=> st.cam_dc[$past(st.cam_waddr)] == $past(st.cam_mask))
    else $error("don't-care mask not stored");
  single_search_a: assert property (search_go && st.cfg.cam_mode == CAM_SINGLE  // [R16]
                                    |-> ##2 (st.match.valid && st.state == ST_IDLE))
    else $error("single-match search not one cycle");
  multi_search_a: assert property (search_go && st.cfg.cam_mode == CAM_MULTI  // [R17]
                                   |-> ##2 st.match.valid ##1 st.match.valid)
    else $error("multiple-match search not two cycles");
  match_flag_a: assert property (st.state == ST_SR1 |=> st.match.flag == $past(|hit_v))  // [R08]
    else $error("match flag wrong");
  enc_addr_a: assert property (st.match.valid && st.cfg.encoded && st.match.flag  // [R12]
                               |-> hit_v[st.match.addr])
    else $error("encoded address not a match");
  lowest_a: assert property (st.match.valid && st.cfg.encoded && st.match.flag  // [R22]
                             |-> (hit_v & ((32'h1 << st.match.addr) - 32'h1)) == 32'h0)
    else $error("encoded address not lowest");
  // Encoded and unencoded results must not leak into each other's fields
  enc_lines_a: assert property (st.match.valid && st.cfg.encoded  // [R11]
                                |-> st.match.lines == 16'h0000)
    else $error("encoded result drove match lines");
  unenc_addr_a: assert property (st.match.valid && !st.cfg.encoded  // [R13]
                                 |-> st.match.addr == 5'h00)
    else $error("unencoded result drove address");
  fast_limit_a: assert property (st.state == ST_SR1 && st.cfg.cam_mode == CAM_FAST  // [R18]
                                 |=> !st.match.addr[4])
    else $error("fast mode reported word above 15");
  bank_sel_a: assert property (st.state == ST_SR1 && st.cfg.cam_mode == CAM_SINGLE  // [R15]
                               && !st.cfg.encoded
                               |=> st.match.lines == ($past(st.key[0]) ? $past(odd_v)
                                                                       : $past(even_v)))
    else $error("unencoded bank select wrong");
  rom_hold_a: assert property (st.cfg.rom_lock && !st.cfg.cam_en |=> $stable(st.mem))  // [R21]
    else $error("locked table changed");
  out_stage_a: assert property (st.cfg.out_reg[0] && !clr_vec[0]  // [R20]
                                |=> st.rdata[0] == $past(st.raw[0]))
    else $error("output stage not one cycle");

  single_hit_c: cover property (st.state == ST_SR1 && st.cfg.cam_mode == CAM_SINGLE ##1
                                st.match.flag);
  multi_run_c: cover property (st.state == ST_SR1 && st.cfg.cam_mode == CAM_MULTI ##1
                               st.state == ST_SR2);
  fast_run_c: cover property (st.state == ST_SR1 && st.cfg.cam_mode == CAM_FAST ##1
                              st.match.flag);
  dc_write_c: cover property (st.state == ST_WR3);
  ram_read_c: cover property (ram_rd && !st.cfg.cam_en);

endmodule : emb_block

// ### common/emb_pkg.sv
// Shared constants and carrier types for the embedded memory block
package emb_pkg;

  // Array geometry
  localparam int unsigned EMB_MEM_ROWS   = 128;  // 4096 bits as 128 rows of 32
  localparam int unsigned EMB_CAM_WORDS  = 32;
  localparam int unsigned EMB_FAST_WORDS = 16;
  localparam int unsigned EMB_LINES      = 16;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] EMB_CTRL_OFS      = 8'h00;
  localparam logic [7:0] EMB_ENA_OFS       = 8'h04;
  localparam logic [7:0] EMB_CLEAR_OFS     = 8'h08;
  localparam logic [7:0] EMB_ADDR_OFS      = 8'h0C;
  localparam logic [7:0] EMB_WDATA_OFS     = 8'h10;
  localparam logic [7:0] EMB_CMD_OFS       = 8'h14;
  localparam logic [7:0] EMB_RDATA_A_OFS   = 8'h18;
  localparam logic [7:0] EMB_RDATA_B_OFS   = 8'h1C;
  localparam logic [7:0] EMB_CAM_WDATA_OFS = 8'h20;
  localparam logic [7:0] EMB_CAM_MASK_OFS  = 8'h24;
  localparam logic [7:0] EMB_CAM_WADDR_OFS = 8'h28;
  localparam logic [7:0] EMB_CAM_KEY_OFS   = 8'h2C;
  localparam logic [7:0] EMB_STATUS_OFS    = 8'h30;

  // Reset values
  localparam logic [10:0] EMB_CTRL_RESET = 11'h000;
  localparam logic [3:0]  EMB_ENA_RESET  = 4'hF;

  // Bit 0 of the key is the bank select in unencoded output
  localparam logic [31:0] EMB_UNENC_CMP_MASK = 32'hFFFF_FFFE;

  typedef enum logic [1:0] {
    CAM_SINGLE = 2'h0,
    CAM_MULTI  = 2'h1,
    CAM_FAST   = 2'h2
  } emb_cam_mode_type;

  // Gray coded along write path and along search path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WR1  = 3'h1,
    ST_WR2  = 3'h3,
    ST_WR3  = 3'h2,
    ST_SR1  = 3'h4,
    ST_SR2  = 3'h5
  } emb_state_type;

  // Control register layout, bit 0 first from the right
  typedef struct packed {
    logic [1:0]       out_reg;   // [10:9] per-port output register stage
    logic             rom_lock;  // [8] block is a read-only lookup table
    logic             split;     // [7] two independent half memories
    logic [2:0]       width;     // [6:4] log2 of data width, 0..5
    logic             encoded;   // [3] encoded match address
    emb_cam_mode_type cam_mode;  // [2:1]
    logic             cam_en;    // [0] block works as CAM
  } emb_cfg_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } emb_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } emb_wb_resp_type;

  typedef struct packed {
    logic [15:0] lines;
    logic        valid;
    logic [4:0]  addr;
    logic        flag;
  } emb_match_type;

endpackage : emb_pkg

// ### verification/emb_user_model.sv
// Fabric user logic model: classic Wishbone master for the memory block
`timescale 1ns/1ps
module emb_user_model
  import emb_pkg::*;
(
  input  logic            ref_clk_in,
  input  emb_wb_resp_type wb_resp_in,
  output emb_wb_req_type  wb_req_out,
  output logic            timeout_out
);
  // Idle bus at time zero
  initial begin
    wb_req_out  = '0;
    timeout_out = 1'b0;
  end

  // One classic cycle; ack and read data are taken at the rising edge that shows ack high
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    wb_req_out <= {1'b1, 1'b1, we, adr, 4'hF, dat};
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wb_resp_in.ack !== 1'b1);
    // The slave answers one cycle after taking the request; a later ack is flagged, not cut off
    if (n > 2) timeout_out = 1'b1;
    rdat = wb_resp_in.dat;
    // Released lines carry inverted values so stale data is never mistaken for valid
    wb_req_out <= {1'b0, 1'b0, ~we, ~adr, 4'h0, ~dat};
  endtask : bus
endmodule : emb_user_model

// ### verification/test_embedded_ram_cam_block.sv
// Self-checking bench for the embedded memory block
`timescale 1ns/1ps
module test_embedded_ram_cam_block
  import emb_pkg::*;
;
  logic            ref_clk;
  logic            reset_n;
  emb_wb_req_type  wb_req;
  emb_wb_resp_type wb_resp;
  emb_match_type   match;
  logic            busy;
  logic            timeout;
  int              err_total;
  int              check_count;
  int              busy_cycles;
  int              valid_count;
  logic [15:0]     seen_lines [2];
  logic [5:0]      seen_hit;
  localparam logic [31:0] D = 32'h0000_7770;

  emb_block DUT (
    .ref_clk_in  (ref_clk),
    .reset_n_in  (reset_n),
    .wb_req_in   (wb_req),
    .wb_resp_out (wb_resp),
    .match_out   (match),
    .busy_out    (busy)
  );

  emb_user_model USR (
    .ref_clk_in  (ref_clk),
    .wb_resp_in  (wb_resp),
    .wb_req_out  (wb_req),
    .timeout_out (timeout)
  );

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Outputs sampled mid-cycle, away from the launching edge
  always @(negedge ref_clk) begin
    if (busy === 1'b1) busy_cycles++;
    if (match.valid === 1'b1) begin
      if (valid_count < 2) seen_lines[valid_count] = match.lines;
      seen_hit = {match.flag, match.addr};
      valid_count++;
    end
  end

  task automatic end_of_test();
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] unused;
    USR.bus(1'b1, adr, dat, unused);
  endtask : wr

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] got;
    USR.bus(1'b0, adr, 32'h0, got);
    chk(got, exp);
  endtask : rd_chk

  // Poll status until the CAM engine is idle; bounded so a stuck busy cannot hang
  task automatic wait_idle();
    logic [31:0] st;
    int n;
    n = 0;
    do begin
      USR.bus(1'b0, EMB_STATUS_OFS, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 20);
    chk(32'(n >= 20), 32'h0);
  endtask : wait_idle

  task automatic ram_op(input logic [31:0] adr, input logic [31:0] dat);
    wr(EMB_ADDR_OFS, adr);
    wr(EMB_WDATA_OFS, dat);
    wr(EMB_CMD_OFS, 32'h1);
    wr(EMB_CMD_OFS, 32'h2);
  endtask : ram_op

  task automatic cam_write(input logic [31:0] adr, input logic [31:0] dat,
                           input logic [31:0] mask);
    wr(EMB_CAM_WDATA_OFS, dat);
    wr(EMB_CAM_MASK_OFS, mask);
    busy_cycles = 0;
    wr(EMB_CAM_WADDR_OFS, adr);
    wait_idle();
  endtask : cam_write

  // Multi mode gives its second result one cycle after the first; wait that out
  task automatic search(input logic [31:0] key);
    valid_count = 0;
    wr(EMB_CAM_KEY_OFS, key);
    wait_idle();
    repeat (2) @(posedge ref_clk);
  endtask : search

  // Watchdog sized well above the whole sequence
  initial begin
    #(25.0 * 40000);
    err_total++;
    end_of_test();
  end

  // Main sequence
  initial begin
    err_total   = 0;
    check_count = 0;
    busy_cycles = 0;
    valid_count = 0;
    seen_hit    = '0;
    reset_n     = 1'b0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd_chk(EMB_CTRL_OFS, 32'h0);
    rd_chk(EMB_ENA_OFS, 32'hF);
    rd_chk(EMB_CMD_OFS, 32'h0);
    rd_chk(8'h3C, 32'h0);
    for (int w = 0; w < 6; w++) begin
      wr(EMB_CTRL_OFS, 32'(w) << 4);
      ram_op(32'h3, 32'hA5C3_5A3C);
      rd_chk(EMB_RDATA_A_OFS, 32'hA5C3_5A3C & 32'((64'h1 << (1 << w)) - 64'h1));
    end
    // Both strobes together only write; the read side keeps its old word
    wr(EMB_WDATA_OFS, 32'h0000_1234);
    wr(EMB_CMD_OFS, 32'h3);
    rd_chk(EMB_RDATA_A_OFS, 32'hA5C3_5A3C);
    wr(EMB_CMD_OFS, 32'h2);
    rd_chk(EMB_RDATA_A_OFS, 32'h0000_1234);
    wr(EMB_CTRL_OFS, 32'hD0);
    ram_op(32'h0, 32'h1111_2222);
    ram_op(32'h1000, 32'h3333_4444);
    rd_chk(EMB_RDATA_A_OFS, 32'h1111_2222);
    rd_chk(EMB_RDATA_B_OFS, 32'h3333_4444);
    wr(EMB_ENA_OFS, 32'hD);
    ram_op(32'h0, 32'h5555_6666);
    rd_chk(EMB_RDATA_A_OFS, 32'h1111_2222);
    wr(EMB_ENA_OFS, 32'hF);
    wr(EMB_CLEAR_OFS, 32'h1);
    rd_chk(EMB_RDATA_A_OFS, 32'h0);
    rd_chk(EMB_RDATA_B_OFS, 32'h3333_4444);
    wr(EMB_CTRL_OFS, 32'h1D0);
    ram_op(32'h0, 32'h7777_8888);
    rd_chk(EMB_RDATA_A_OFS, 32'h1111_2222);
    // Output stage on port A only adds latency; port B keeps its word
    wr(EMB_CTRL_OFS, 32'h2D0);
    ram_op(32'h0, 32'h9999_AAAA);
    rd_chk(EMB_RDATA_A_OFS, 32'h9999_AAAA);
    rd_chk(EMB_RDATA_B_OFS, 32'h3333_4444);
    // Second reset in mid-run clears memory and control
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd_chk(EMB_CTRL_OFS, 32'h0);
    wr(EMB_CTRL_OFS, 32'h50);
    wr(EMB_CMD_OFS, 32'h2);
    rd_chk(EMB_RDATA_A_OFS, 32'h0);
    wr(EMB_CTRL_OFS, 32'h09);
    cam_write(32'd12, 32'hFA12_0000, 32'h0);
    chk(32'(busy_cycles), 32'd2);
    search(32'hFA12_0000);
    chk(32'(valid_count), 32'd1);
    chk(32'(seen_hit), {26'h0, 1'b1, 5'd12});
    search(32'hFA12_0001);
    chk(32'(seen_hit[5]), 32'h0);
    cam_write(32'd5, 32'hAAAA_0000, 32'h0000_FFFF);
    chk(32'(busy_cycles), 32'd3);
    search(32'hAAAA_1234);
    chk(32'(seen_hit), {26'h0, 1'b1, 5'd5});
    cam_write(32'd4, D, 32'h0);
    cam_write(32'd7, D, 32'h0);
    cam_write(32'd20, D, 32'h0);
    wr(EMB_CTRL_OFS, 32'h03);
    search(D);
    chk(32'(valid_count), 32'd2);
    chk(32'(seen_lines[0]), 32'h0404);
    chk(32'(seen_lines[1]), 32'h0008);
    wr(EMB_CTRL_OFS, 32'h0B);
    search(D);
    chk(32'(seen_hit), {26'h0, 1'b1, 5'd4});
    wr(EMB_CTRL_OFS, 32'h01);
    search(D | 32'h1);
    chk(32'(seen_lines[0]), 32'h0008);
    search(D);
    chk(32'(seen_lines[0]), 32'h0404);
    wr(EMB_CTRL_OFS, 32'h05);
    search(D);
    chk(32'(valid_count), 32'd1);
    chk(32'(seen_lines[0]), 32'h0090);
    wr(EMB_CTRL_OFS, 32'h0D);
    search(D);
    chk(32'(seen_hit), {26'h0, 1'b1, 5'd4});
    chk(32'(timeout), 32'h0);
    end_of_test();
  end
endmodule : test_embedded_ram_cam_block
